// file: logic/capture_compare_pkg.sv
// constants, register map and carriers shared by the capture/compare channel
package capture_compare_pkg;

  // bus geometry
  localparam int ADDR_W  = 8;
  localparam int DATA_W  = 32;
  localparam int TIMER_W = 16;

  // register byte offsets
  localparam logic [ADDR_W-1:0] CTRL_OFS    = 8'h00;
  localparam logic [ADDR_W-1:0] TIMER_OFS   = 8'h04;
  localparam logic [ADDR_W-1:0] CMP_OFS     = 8'h08;
  localparam logic [ADDR_W-1:0] CAPT_OFS    = 8'h0C;
  localparam logic [ADDR_W-1:0] STATUS_OFS  = 8'h10;
  localparam logic [ADDR_W-1:0] MASK_OFS    = 8'h14;
  localparam logic [ADDR_W-1:0] FILL_OFS    = 8'h18;

  // field positions inside the fill register
  localparam int FILL_BUF_BIT  = 0;
  localparam int FILL_TIME_BIT = 1;

  // channel_control_reg layout, bit 0 is the overwrite control
  typedef struct packed {
    logic clr_on_capt;  // bit 7: a capture resets the timer
    logic count_down;   // bit 6
    logic run;          // bit 5
    logic cmp_en;       // bit 4
    logic edge_fall;    // bit 3
    logic edge_rise;    // bit 2
    logic capt_en;      // bit 1
    logic overwrite;    // bit 0
  } ctrl_s;

  localparam int CTRL_W = $bits(ctrl_s);

  // sticky event status and mask layout
  typedef struct packed {
    logic compare;      // bit 2
    logic overrun;      // bit 1: overrun_flag
    logic capture;      // bit 0: channel interrupt pending
  } status_s;

  localparam int STATUS_W = $bits(status_s);

  // reset values
  localparam logic [CTRL_W-1:0]   CTRL_RESET   = 8'h00;
  localparam logic [STATUS_W-1:0] STATUS_RESET = 3'h0;
  localparam logic [STATUS_W-1:0] MASK_RESET   = 3'h0;
  localparam logic [TIMER_W-1:0]  TIMER_RESET  = 16'h0000;
  localparam logic [TIMER_W-1:0]  CMP_RESET    = 16'h0000;
  localparam logic [TIMER_W-1:0]  CAPT_RESET   = 16'h0000;

endpackage : capture_compare_pkg

// file: logic/event_edge_detect.sv
// synchroniser and edge qualifier for the external event input
module event_edge_detect (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic event_pin,
  input  wire logic rise_en,
  input  wire logic fall_en,
  output logic      edge_valid
);

  logic sync1_q;
  logic sync2_q;
  logic prev_q;

  // two-flop synchroniser; sync1_q feeds nothing but sync2_q
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      sync1_q <= event_pin;
      sync2_q <= sync1_q;
    end
  end

  // history of the settled level and a registered edge pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q     <= 1'b0;
      edge_valid <= 1'b0;
    end else begin
      prev_q     <= sync2_q;
      edge_valid <= (rise_en & sync2_q & ~prev_q) | (fall_en & ~sync2_q & prev_q);
    end
  end

endmodule : event_edge_detect

// file: logic/event_capture_compare_channel.sv
// one capture/compare channel of the event processing array, APB slave
module event_capture_compare_channel #(
  parameter int TW = capture_compare_pkg::TIMER_W
) (
  input  wire logic                                 pclk,
  input  wire logic                                 presetn,
  input  wire logic                                 psel,
  input  wire logic                                 penable,
  input  wire logic                                 pwrite,
  input  wire logic [capture_compare_pkg::ADDR_W-1:0] paddr,
  input  wire logic [capture_compare_pkg::DATA_W-1:0] pwdata,
  output logic      [capture_compare_pkg::DATA_W-1:0] prdata,
  output logic                                      pready,
  output logic                                      pslverr,
  input  wire logic                                 event_in,
  output logic      [TW-1:0]                        timer_value,
  output logic                                      compare_match,
  output logic                                      irq
);
  import capture_compare_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  ctrl_s                ctrl_q;
  status_s              status_q;
  status_s              mask_q;
  logic [TW-1:0]        timer_q;
  logic [TW-1:0]        timer_d;
  logic [TW-1:0]        cmp_q;
  logic [TW-1:0]        capt_q;
  logic [TW-1:0]        capt_d;
  logic [TW-1:0]        buf_q;
  logic [TW-1:0]        buf_d;
  logic                 capt_full_q;
  logic                 capt_full_d;
  logic                 buf_full_q;
  logic                 buf_full_d;
  logic                 match_q;

  // bus decode
  logic                 setup_rd;
  logic                 access;
  logic                 wr;
  logic                 rd;
  logic                 addr_hit;
  logic                 wr_ctrl;
  logic                 wr_timer;
  logic                 wr_cmp;
  logic                 wr_status;
  logic                 wr_mask;
  logic                 rd_capt;

  // capture pipeline
  logic                 edge_valid;
  logic                 capt_edge;
  logic                 time_left;
  logic                 move_buf;
  logic                 full_after_move;
  logic                 buf_after_move;
  logic                 edge_to_buf;
  logic                 move_edge;
  logic                 collide;
  logic                 set_capture;
  logic                 set_overrun;

  // timer
  logic                 step;
  logic [TW-1:0]        step_val;
  logic                 tmr_clear;
  logic                 set_compare;

  // ---------------------------------------------------------------
  // external event input: synchronised and edge-qualified
  // ---------------------------------------------------------------
  event_edge_detect u_edge (
    .pclk       (pclk),
    .presetn    (presetn),
    .event_pin  (event_in),
    .rise_en    (ctrl_q.edge_rise),
    .fall_en    (ctrl_q.edge_fall),
    .edge_valid (edge_valid)
  );

  assign capt_edge = edge_valid & ctrl_q.capt_en;

  // ---------------------------------------------------------------
  // APB decode; zero wait states, reads staged in the setup cycle
  // ---------------------------------------------------------------
  assign access   = psel & penable;
  assign setup_rd = psel & ~penable & ~pwrite;
  assign wr       = access & pwrite;
  assign rd       = access & ~pwrite;

  always_comb begin
    unique case (paddr)
      CTRL_OFS, TIMER_OFS, CMP_OFS, CAPT_OFS,
      STATUS_OFS, MASK_OFS, FILL_OFS: addr_hit = 1'b1;
      default:                        addr_hit = 1'b0;
    endcase
  end

  assign pready    = 1'b1;
  assign pslverr   = access & ~addr_hit;  // unmapped: error, no effect
  assign wr_ctrl   = wr & (paddr == CTRL_OFS);
  assign wr_timer  = wr & (paddr == TIMER_OFS);
  assign wr_cmp    = wr & (paddr == CMP_OFS);
  assign wr_status = wr & (paddr == STATUS_OFS);
  assign wr_mask   = wr & (paddr == MASK_OFS);
  assign rd_capt   = rd & (paddr == CAPT_OFS);

  // read data captured in setup; a read pulls the capture register only at
  // the access edge, so the value returned is the one before the pull
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (setup_rd) begin
      unique case (paddr)
        CTRL_OFS:   prdata <= DATA_W'(ctrl_q);
        TIMER_OFS:  prdata <= DATA_W'(timer_q);
        CMP_OFS:    prdata <= DATA_W'(cmp_q);
        CAPT_OFS:   prdata <= DATA_W'(capt_q);
        STATUS_OFS: prdata <= DATA_W'(status_q);
        MASK_OFS:   prdata <= DATA_W'(mask_q);
        FILL_OFS: begin
          prdata                <= '0;
          prdata[FILL_BUF_BIT]  <= buf_full_q;
          prdata[FILL_TIME_BIT] <= capt_full_q;
        end
        default:    prdata <= '0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // control, compare and mask registers
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RESET;
      cmp_q  <= CMP_RESET;
      mask_q <= MASK_RESET;
    end else begin
      if (wr_ctrl) ctrl_q <= ctrl_s'(pwdata[CTRL_W-1:0]);
      if (wr_cmp)  cmp_q  <= pwdata[TW-1:0];
      if (wr_mask) mask_q <= status_s'(pwdata[STATUS_W-1:0]);
    end
  end

  // ---------------------------------------------------------------
  // capture path: read, buffer move, new edge, immediate move
  // ---------------------------------------------------------------
  always_comb begin
    // a read consumes the register contents
    time_left       = capt_full_q & ~rd_capt;
    move_buf        = buf_full_q & ~time_left;
    full_after_move = time_left | move_buf;
    buf_after_move  = buf_full_q & ~move_buf;
    // an edge finds the buffer free, or collides with held data
    edge_to_buf     = capt_edge & (~buf_after_move | ctrl_q.overwrite);
    set_overrun     = capt_edge & buf_after_move & full_after_move;
    // with the register empty the fresh value goes straight through
    move_edge       = edge_to_buf & ~full_after_move;
    // defect kept for compatibility: a pull that coincides with an
    // overwriting edge on full stages leaves both full, nothing pending
    collide         = rd_capt & buf_full_q & capt_full_q
                      & capt_edge & ctrl_q.overwrite;
    set_capture     = (move_buf & ~collide) | move_edge;

    capt_d      = capt_q;
    capt_full_d = full_after_move;
    buf_d       = buf_q;
    buf_full_d  = buf_after_move;
    if (move_buf) begin
      capt_d = buf_q;
    end
    if (move_edge) begin
      capt_d      = timer_q;
      capt_full_d = 1'b1;
    end else if (edge_to_buf) begin
      buf_d      = timer_q;
      buf_full_d = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capt_q      <= CAPT_RESET;
      buf_q       <= CAPT_RESET;
      capt_full_q <= 1'b0;
      buf_full_q  <= 1'b0;
    end else begin
      capt_q      <= capt_d;
      buf_q       <= buf_d;
      capt_full_q <= capt_full_d;
      buf_full_q  <= buf_full_d;
    end
  end

  // ---------------------------------------------------------------
  // timer and compare
  // ---------------------------------------------------------------
  // software writes race a channel reset; the reset is given priority
  // here, though software must not rely on it
  assign tmr_clear = capt_edge & ctrl_q.clr_on_capt;
  assign step      = ctrl_q.run & ~tmr_clear & ~wr_timer;
  assign step_val  = ctrl_q.count_down ? timer_q - TW'(1) : timer_q + TW'(1);

  always_comb begin
    timer_d = timer_q;
    if (tmr_clear) begin
      timer_d = TIMER_RESET;
    end else if (wr_timer) begin
      timer_d = pwdata[TW-1:0];
    end else if (step) begin
      timer_d = step_val;
    end
  end

  // loads and resets land on the value without a match; only a count
  // step onto the compare value fires
  assign set_compare = ctrl_q.cmp_en & step & (step_val == cmp_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_q <= TIMER_RESET;
      match_q <= 1'b0;
    end else begin
      timer_q <= timer_d;
      match_q <= set_compare;
    end
  end

  assign timer_value   = timer_q;
  assign compare_match = match_q;

  // ---------------------------------------------------------------
  // sticky status, write one to clear; a set in the same cycle wins
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= STATUS_RESET;
    end else begin
      if (wr_status) begin
        status_q <= status_q & ~status_s'(pwdata[STATUS_W-1:0]);
      end
      if (set_capture) status_q.capture <= 1'b1;
      if (set_overrun) status_q.overrun <= 1'b1;
      if (set_compare) status_q.compare <= 1'b1;
    end
  end

  // level interrupt; software should re-read status before returning,
  // since a pull during service can set capture again
  assign irq = |(status_q & mask_q);

endmodule : event_capture_compare_channel

// file: testbench/capture_compare_assertions.sv
// port-level checker for the capture/compare channel
module capture_compare_assertions
  import capture_compare_pkg::*;
#(
  parameter int TW = TIMER_W
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [DATA_W-1:0] prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              event_in,
  input wire logic [TW-1:0]     timer_value,
  input wire logic              compare_match,
  input wire logic              irq
);
  logic [CTRL_W-1:0]   ctrl_q;
  logic [TW-1:0]       cmp_q;
  logic [STATUS_W-1:0] mask_q;
  logic                acc;
  logic                wr_tmr;
  logic                wr_ctl;
  assign acc    = psel && penable;
  assign wr_tmr = acc && pwrite && paddr == TIMER_OFS;
  assign wr_ctl = acc && pwrite && paddr == CTRL_OFS;
  // shadow of written settings, so each check knows the mode in force
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RESET;
      cmp_q  <= CMP_RESET;
      mask_q <= MASK_RESET;
    end else if (acc && pwrite) begin
      if (paddr == CTRL_OFS) ctrl_q <= pwdata[CTRL_W-1:0];
      if (paddr == CMP_OFS) cmp_q <= pwdata[TW-1:0];
      if (paddr == MASK_OFS) mask_q <= pwdata[STATUS_W-1:0];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_high: assert property (psel |-> pready) else $error("pready low");
  a_slverr_hole: assert property (acc && paddr > FILL_OFS |-> pslverr && (pwrite || prdata == 0))
    else $error("unmapped access not refused");
  a_slverr_mapped: assert property (acc && paddr <= FILL_OFS && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("mapped access refused");
  a_match_single: assert property (compare_match |=> !compare_match)
    else $error("match longer than one cycle");
  a_match_value: assert property (compare_match |-> timer_value == cmp_q ||
    $past(timer_value) == cmp_q) else $error("match away from compare value");
  a_timer_hold: assert property (!ctrl_q[5] && !ctrl_q[7] && !wr_tmr && !wr_ctl |=>
    $stable(timer_value)) else $error("stopped timer moved");
  a_timer_step: assert property (ctrl_q[5] && !ctrl_q[6] && !ctrl_q[7] && !wr_tmr && !wr_ctl
    |=> timer_value == $past(timer_value) + 1'b1) else $error("timer missed a count");
  a_irq_masked: assert property (mask_q == 0 |-> !irq) else $error("masked irq raised");
endmodule : capture_compare_assertions

bind event_capture_compare_channel capture_compare_assertions #(.TW(TW)) chk_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .event_in(event_in), .timer_value(timer_value), .compare_match(compare_match), .irq(irq)
);

// file: testbench/event_source.sv
// external event pin model: a fire request gives one three-cycle high pulse
module event_source (
  input wire logic pclk,
  input wire logic fire,
  output logic     event_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] left_q = 2'h0;
  // pulse held three cycles so the synchroniser cannot miss it
  always_ff @(posedge pclk) begin
    left_q <= fire ? 2'h3 : (left_q != 0 ? left_q - 2'h1 : 2'h0);
  end
  assign event_in = left_q != 0;
endmodule : event_source

// file: testbench/tb_top.sv
// self-checking bench for the capture/compare channel
module tb_top
  import capture_compare_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, event_in, compare_match, irq;
  logic fire, err;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rd;
  logic [TIMER_W-1:0] timer_value, cv;
  logic [TIMER_W-1:0] v [5];
  int fails, check_count;
  integer seed;
  event_capture_compare_channel dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .event_in(event_in), .timer_value(timer_value), .compare_match(compare_match), .irq(irq)
  );
  event_source src_u (.pclk(pclk), .fire(fire), .event_in(event_in));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic stop_test;
    $display("fails=%0d check_count=%0d", fails, check_count);
    if (fails == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  // one transfer; the bus is left up so a next setup may follow at once
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
  endtask : apb
  task automatic idle(input int n);
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (n) @(posedge pclk);
  endtask : idle
  // irq looked at mid-cycle, where register updates have landed
  task automatic irq_is(input logic e);
    idle(0);
    @(negedge pclk);
    chk(irq, e, "irq");
    @(posedge pclk);
  endtask : irq_is
  task automatic ev(input logic [TIMER_W-1:0] t);
    apb(1'b1, TIMER_OFS, t);
    idle(0);
    fire <= 1'b1;
    @(posedge pclk);
    fire <= 1'b0;
    repeat (10) @(posedge pclk);
  endtask : ev
  initial begin
    #300000;
    fails++;
    stop_test();
  end
  initial begin
    seed = 2;
    {psel, penable, pwrite, fire, presetn, paddr, pwdata} = '0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // every register clears on reset; the word past the map is refused
    for (int a = 0; a <= 28; a += 4) begin
      apb(1'b0, ADDR_W'(a), '0);
      chk(rd, '0, "reset value");
      chk(err, a == 28, "slverr");
    end
    apb(1'b1, MASK_OFS, 32'h7);
    apb(1'b1, CTRL_OFS, 32'h6);
    for (int i = 0; i < 3; i++) begin
      v[i] = TIMER_W'($random(seed));
      ev(v[i]);
    end
    apb(1'b0, FILL_OFS, '0);
    chk(rd, 32'h3, "fill");
    apb(1'b0, STATUS_OFS, '0);
    chk(rd, 32'h3, "status");
    apb(1'b1, MASK_OFS, '0);
    irq_is(1'b0);
    apb(1'b1, MASK_OFS, 32'h7);
    irq_is(1'b1);
    apb(1'b1, STATUS_OFS, 32'h7);
    irq_is(1'b0);
    apb(1'b0, CAPT_OFS, '0);
    chk(rd, v[0], "first capture");
    irq_is(1'b1);
    apb(1'b0, CAPT_OFS, '0);
    chk(rd, v[1], "buffered capture");
    // handler rechecks pending before leaving: the pull set capture again
    apb(1'b0, STATUS_OFS, '0);
    chk(rd, 32'h1, "pending recheck");
    apb(1'b1, STATUS_OFS, 32'h7);
    apb(1'b1, CTRL_OFS, 32'h7);
    for (int i = 2; i < 5; i++) begin
      v[i] = TIMER_W'($random(seed));
      ev(v[i]);
    end
    apb(1'b0, CAPT_OFS, '0);
    chk(rd, v[2], "direct capture");
    apb(1'b0, CAPT_OFS, '0);
    chk(rd, v[4], "newest capture kept");
    apb(1'b0, STATUS_OFS, '0);
    chk(rd[1], 1'b1, "overrun");
    // loading the compare value must not match, counting onto it must
    cv = TIMER_W'($random(seed));
    apb(1'b1, CMP_OFS, cv);
    apb(1'b1, CTRL_OFS, 32'h10);
    apb(1'b1, STATUS_OFS, 32'h7);
    apb(1'b1, TIMER_OFS, cv);
    idle(3);
    apb(1'b0, STATUS_OFS, '0);
    chk(rd[2], 1'b0, "load match");
    for (int dn = 0; dn < 2; dn++) begin
      apb(1'b1, CTRL_OFS, '0);
      apb(1'b1, STATUS_OFS, 32'h7);
      apb(1'b1, TIMER_OFS, dn ? cv + 16'h4 : cv - 16'h4);
      apb(1'b1, CTRL_OFS, dn ? 32'h70 : 32'h30);
      // the fourth step lands on the compare value; the pulse rises with it
      idle(0);
      repeat (3) @(posedge pclk);
      @(negedge pclk);
      chk(compare_match, 1'b0, "early match");
      chk(timer_value, TIMER_W'(dn ? cv + 16'h1 : cv - 16'h1), "timer step");
      @(negedge pclk);
      chk(compare_match, 1'b1, "match pulse");
      chk(timer_value, cv, "timer at match");
      @(posedge pclk);
      idle(5);
      apb(1'b0, STATUS_OFS, '0);
      chk(rd[2], 1'b1, "count match");
    end
    // compare at zero, then a capture clears the timer; the event task writes the timer just before it fires
    apb(1'b1, CTRL_OFS, '0);
    apb(1'b1, CMP_OFS, '0);
    apb(1'b1, STATUS_OFS, 32'h7);
    // start far from zero so only the capture reset can bring the timer there
    apb(1'b1, TIMER_OFS, 32'h1000);
    apb(1'b1, CTRL_OFS, 32'hB6);
    ev(16'h1000);
    apb(1'b0, TIMER_OFS, '0);
    chk(rd < 32'h40, 1'b1, "timer cleared");
    apb(1'b0, STATUS_OFS, '0);
    chk(rd[2], 1'b0, "reset match");
    apb(1'b1, CTRL_OFS, '0);
    idle(2);
    stop_test();
  end
endmodule : tb_top
